//--- hdl/wwdg_pkg.sv
// constants of the halt-aware windowed watchdog: offsets, fields, timing
// assumes a 50 MHz clock that is also the divided oscillator clock
//
// Overview of operation
// - count decrements once per 16384 clocks
// - leaving 40h for 3Fh requests chip reset
// - activation bit set by software only
// - inactive never resets, active expiry resets
// - control register resets to 7Fh
// - hardware option forces watchdog always active
// - plain halt: no reset, one decrement, stop
// - interrupt wake restarts after 256/4096 clocks
// - reset out of halt leaves watchdog disabled unless hardware option set
// - halt with halt-reset option, if active, gives reset
// - rtc enabled: active-halt freezes, wakes at once
// - reset out of active-halt delays counting
// - slow and wait modes change nothing
// - counter runs even when not activated
// - watchdog reset drives pin low 500ns
// - activate with sign clear: immediate reset
package wwdg_pkg;
	localparam logic [7:0] CTRL_OFF = 8'h2A;
	localparam logic [7:0] STATUS_OFF = 8'h30;
	localparam logic [7:0] MASK_OFF = 8'h31;
	localparam logic [7:0] CTRL_RESET = 8'h7F;
	localparam int ACT_BIT = 7;
	localparam int SIGN_BIT = 6;
	localparam int COUNT_W = 7;
	localparam logic [6:0] EXPIRE_VAL = 7'h40;
	localparam logic [6:0] COUNT_ONE = 7'h01;
	localparam int IRQ_W = 3;
	localparam int EV_IDLE_EXPIRY = 0;
	localparam int EV_HALT_ENTRY = 1;
	localparam int EV_WAKE_DONE = 2;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	localparam int CLK_HZ = 50000000;
	localparam int PRESCALE_CYC = 16384;
	localparam int RST_PULSE_NS = 500;
	localparam int RST_PULSE_CYC =
		(RST_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int PULSE_W = 5;
	localparam int WAKE_SHORT_CYC = 256;
	localparam int WAKE_LONG_CYC = 4096;
	localparam int WAKE_W = 13;
	typedef enum logic [2:0] {
		WWDG_STARTUP,
		WWDG_RUN,
		WWDG_HALT,
		WWDG_ACT_HALT,
		WWDG_WAKE
	} wwdg_state_type;
endpackage : wwdg_pkg

//--- hdl/wwdg_prescaler.sv
// free-running divider giving one tick per PRESCALE_CYC clocks
// assumes nothing but clk and reset; it has no clear input on purpose
`timescale 1ns/1ps
`default_nettype none
module wwdg_prescaler #(
	parameter int PRESCALE_CYC = wwdg_pkg::PRESCALE_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	output logic tick
);
	localparam int W = $clog2(PRESCALE_CYC);
	localparam logic [W-1:0] LAST = W'(PRESCALE_CYC - 1);
	logic [W-1:0] cnt;

	// never cleared by reloads, so the first decrement may come early
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt <= '0;
		else if (cnt == LAST)
			cnt <= '0;
		else
			cnt <= cnt + 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			tick <= 1'b0;
		else
			tick <= (cnt == LAST);
	end
endmodule : wwdg_prescaler
`default_nettype wire

//--- hdl/wwdg_delay.sv
// one-shot wake delay of 256 or 4096 clocks, done is a one-cycle pulse
// assumes start is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module wwdg_delay (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic start,
	input wire logic long_sel,
	output logic done
);
	localparam logic [12:0] SHORT_LOAD = 13'(wwdg_pkg::WAKE_SHORT_CYC - 1);
	localparam logic [12:0] LONG_LOAD = 13'(wwdg_pkg::WAKE_LONG_CYC - 1);
	logic [wwdg_pkg::WAKE_W-1:0] cnt;
	logic busy;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt <= '0;
			busy <= 1'b0;
		end
		else if (start)
		begin
			cnt <= long_sel ? LONG_LOAD : SHORT_LOAD;
			busy <= 1'b1;
		end
		else if (busy)
		begin
			cnt <= cnt - 1'b1;
			busy <= (cnt != 13'h0001);
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			done <= 1'b0;
		else
			done <= busy && !start && (cnt == 13'h0001);
	end
endmodule : wwdg_delay
`default_nettype wire

//--- hdl/wwdg_top.sv
// halt-aware watchdog: control register, down-counter, halt handling,
// reset pulse generation and a small interrupt status/mask pair
// assumes straps are stable from reset release; ext_irq_pin is a pin,
// every other input comes from logic on clk
`timescale 1ns/1ps
`default_nettype none
module wwdg_top #(
	parameter int PRESCALE_CYC = wwdg_pkg::PRESCALE_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic hw_wdg_option,
	input wire logic halt_reset_option,
	input wire logic wake_delay_long,
	input wire logic active_halt_reset,
	input wire logic rtc_irq_enable,
	input wire logic halt_req,
	input wire logic ext_irq_pin,
	input wire logic osc_irq,
	output logic chip_reset_req,
	output logic rst_pin_o,
	output logic rst_pin_oe,
	output logic cpu_halted,
	output logic irq
);
	wwdg_pkg::wwdg_state_type state;
	wwdg_pkg::wwdg_state_type next_state;
	logic activation_bit;
	logic [wwdg_pkg::COUNT_W-1:0] count;
	logic hw_opt;
	logic halt_reset_opt;
	logic long_sel;
	logic [wwdg_pkg::IRQ_W-1:0] status;
	logic [wwdg_pkg::IRQ_W-1:0] mask;
	logic [wwdg_pkg::IRQ_W-1:0] events;
	logic [wwdg_pkg::PULSE_W-1:0] pulse_cnt;
	logic ext_meta;
	logic ext_sync;
	logic tick;
	logic delay_done;
	logic delay_start;
	logic delay_long;
	logic ctrl_wr;
	logic status_wr;
	logic mask_wr;
	logic active_eff;
	logic counting;
	logic halt_entry;
	logic halt_rst;
	logic go_halt;
	logic go_act;
	logic run_dec;
	logic expire_fire;
	logic sw_fire;
	logic fire;
	logic [wwdg_pkg::PULSE_W-1:0] oe_run;

	wwdg_prescaler #(
		.PRESCALE_CYC(PRESCALE_CYC)
	) u_prescaler (
		.clk(clk),
		.arst_n(arst_n),
		.tick(tick)
	);

	wwdg_delay u_delay (
		.clk(clk),
		.arst_n(arst_n),
		.start(delay_start),
		.long_sel(delay_long),
		.done(delay_done)
	);

	// external wake line crosses in through two flops
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
		end
		else
		begin
			ext_meta <= ext_irq_pin;
			ext_sync <= ext_meta;
		end
	end

	// straps caught in the first cycle after reset release
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hw_opt <= 1'b0;
			halt_reset_opt <= 1'b0;
			long_sel <= 1'b0;
		end
		else if (state == wwdg_pkg::WWDG_STARTUP)
		begin
			hw_opt <= hw_wdg_option;
			halt_reset_opt <= halt_reset_option;
			long_sel <= wake_delay_long;
		end
	end

	assign ctrl_wr = reg_wr && (reg_addr == wwdg_pkg::CTRL_OFF);
	assign status_wr = reg_wr && (reg_addr == wwdg_pkg::STATUS_OFF);
	assign mask_wr = reg_wr && (reg_addr == wwdg_pkg::MASK_OFF);
	assign active_eff = hw_opt || activation_bit;
	// slow and wait have no input here: they cannot disturb counting
	assign counting = (state == wwdg_pkg::WWDG_RUN);
	assign run_dec = counting && tick;
	assign halt_entry = halt_req && counting;
	assign halt_rst = halt_entry && !rtc_irq_enable && halt_reset_opt
		&& active_eff;
	assign go_halt = halt_entry && !rtc_irq_enable && !halt_rst;
	assign go_act = halt_entry && rtc_irq_enable;
	assign expire_fire = run_dec && !ctrl_wr && active_eff
		&& (count == wwdg_pkg::EXPIRE_VAL);
	assign sw_fire = ctrl_wr && !reg_wdata[wwdg_pkg::SIGN_BIT]
		&& (active_eff || reg_wdata[wwdg_pkg::ACT_BIT]);
	assign fire = expire_fire || sw_fire || halt_rst;

	assign delay_start = (state == wwdg_pkg::WWDG_STARTUP && active_halt_reset)
		|| (state == wwdg_pkg::WWDG_HALT && ext_sync);
	assign delay_long = (state == wwdg_pkg::WWDG_STARTUP) ? wake_delay_long
		: long_sel;

	always_comb
	begin
		events = '0;
		events[wwdg_pkg::EV_IDLE_EXPIRY] = run_dec && !ctrl_wr && !active_eff
			&& (count == wwdg_pkg::EXPIRE_VAL);
		events[wwdg_pkg::EV_HALT_ENTRY] = go_halt || go_act;
		events[wwdg_pkg::EV_WAKE_DONE] = (state == wwdg_pkg::WWDG_WAKE
			&& delay_done) || (state == wwdg_pkg::WWDG_ACT_HALT
			&& (ext_sync || osc_irq));
	end

	always_comb
	begin
		next_state = state;
		case (state)
			wwdg_pkg::WWDG_STARTUP:
				// a reset out of active-halt waits before counting
				next_state = active_halt_reset ? wwdg_pkg::WWDG_WAKE
					: wwdg_pkg::WWDG_RUN;
			wwdg_pkg::WWDG_RUN:
				if (go_halt)
					next_state = wwdg_pkg::WWDG_HALT;
				else if (go_act)
					next_state = wwdg_pkg::WWDG_ACT_HALT;
			wwdg_pkg::WWDG_HALT:
				if (ext_sync)
					next_state = wwdg_pkg::WWDG_WAKE;
			wwdg_pkg::WWDG_ACT_HALT:
				if (ext_sync || osc_irq)
					next_state = wwdg_pkg::WWDG_RUN;
			wwdg_pkg::WWDG_WAKE:
				if (delay_done)
					next_state = wwdg_pkg::WWDG_RUN;
			default:
				next_state = wwdg_pkg::WWDG_STARTUP;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			state <= wwdg_pkg::WWDG_STARTUP;
		else
			state <= next_state;
	end

	// only a reset clears activation; out of halt it comes up off
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			activation_bit <= wwdg_pkg::CTRL_RESET[wwdg_pkg::ACT_BIT];
		else if (ctrl_wr && reg_wdata[wwdg_pkg::ACT_BIT])
			activation_bit <= 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			count <= wwdg_pkg::CTRL_RESET[wwdg_pkg::COUNT_W-1:0];
		else if (ctrl_wr)
			count <= reg_wdata[wwdg_pkg::COUNT_W-1:0];
		else if (run_dec || go_halt)
			count <= count - wwdg_pkg::COUNT_ONE;
	end

	// reset request and open-drain pin held low for the pulse length
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pulse_cnt <= '0;
			rst_pin_oe <= 1'b0;
			chip_reset_req <= 1'b0;
			rst_pin_o <= 1'b0;
		end
		else
		begin
			if (fire)
				pulse_cnt <= wwdg_pkg::PULSE_W'(wwdg_pkg::RST_PULSE_CYC);
			else if (pulse_cnt != '0)
				pulse_cnt <= pulse_cnt - 1'b1;
			rst_pin_oe <= fire || (pulse_cnt > 5'h01);
			chip_reset_req <= fire || (pulse_cnt > 5'h01);
			rst_pin_o <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cpu_halted <= 1'b0;
		else
			cpu_halted <= (next_state == wwdg_pkg::WWDG_HALT)
				|| (next_state == wwdg_pkg::WWDG_ACT_HALT);
	end

	// sticky events, write one to clear; a new event beats the clear
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			status <= wwdg_pkg::IRQ_RESET;
		else if (status_wr)
			status <= (status & ~reg_wdata[wwdg_pkg::IRQ_W-1:0]) | events;
		else
			status <= status | events;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			mask <= wwdg_pkg::IRQ_RESET;
		else if (mask_wr)
			mask <= reg_wdata[wwdg_pkg::IRQ_W-1:0];
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irq <= 1'b0;
		else
			irq <= |(status & mask);
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 8'h00;
		else if (!reg_rd)
			reg_rdata <= 8'h00;
		else
			case (reg_addr)
				wwdg_pkg::CTRL_OFF:
					reg_rdata <= {activation_bit, count};
				wwdg_pkg::STATUS_OFF:
					reg_rdata <= {5'h00, status};
				wwdg_pkg::MASK_OFF:
					reg_rdata <= {5'h00, mask};
				default:
					reg_rdata <= 8'h00;
			endcase
	end

	// cycles the reset pin has been pulled so far, for the checks below
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			oe_run <= '0;
		else if (!rst_pin_oe || fire)
			oe_run <= '0;
		else
			oe_run <= oe_run + 1'b1;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	act_sticky_a: assert property (activation_bit |=> activation_bit)
		else $error("activation bit was cleared");
	no_idle_reset_a: assert property (fire |-> (active_eff
		|| (ctrl_wr && reg_wdata[wwdg_pkg::ACT_BIT])))
		else $error("reset fired while watchdog inactive");
	hw_forced_a: assert property ((hw_opt && !activation_bit
		&& run_dec && !ctrl_wr && count == wwdg_pkg::EXPIRE_VAL)
		|=> chip_reset_req)
		else $error("hardware option did not force active");
	count_step_a: assert property ((run_dec && !ctrl_wr)
		|=> count == $past(count) - wwdg_pkg::COUNT_ONE)
		else $error("counter did not decrement on tick");
	expiry_reset_a: assert property ((run_dec && !ctrl_wr && active_eff
		&& count == wwdg_pkg::EXPIRE_VAL) |=> rst_pin_oe && chip_reset_req)
		else $error("expiry did not request reset");
	pulse_len_a: assert property ($rose(rst_pin_oe)
		|-> rst_pin_oe[*8] ##18 !rst_pin_oe || $past(fire))
		else $error("reset pulse length wrong");
	pulse_cap_a: assert property (rst_pin_oe
		|-> oe_run < wwdg_pkg::RST_PULSE_CYC)
		else $error("reset pulse ran too long");
	pulse_full_a: assert property ($fell(rst_pin_oe)
		|-> oe_run == wwdg_pkg::RST_PULSE_CYC)
		else $error("reset pulse ended early");
	startup_wait_a: assert property ((state == wwdg_pkg::WWDG_STARTUP
		&& active_halt_reset) |=> !counting [*8])
		else $error("counting began right after active-halt reset");
	halt_quiet_a: assert property ((state == wwdg_pkg::WWDG_HALT
		&& !ctrl_wr) |=> $stable(count) && !chip_reset_req)
		else $error("counter moved or reset during halt");
	halt_reset_a: assert property (halt_rst |=> rst_pin_oe
		&& state == wwdg_pkg::WWDG_RUN)
		else $error("halt with reset option did not reset");
	act_halt_a: assert property (go_act |=> state == wwdg_pkg::WWDG_ACT_HALT
		&& cpu_halted)
		else $error("rtc enabled halt missed active-halt");
	act_wake_a: assert property ((state == wwdg_pkg::WWDG_ACT_HALT
		&& (ext_sync || osc_irq)) |=> counting)
		else $error("active-halt did not wake at once");
	wake_delay_a: assert property ((state == wwdg_pkg::WWDG_HALT && ext_sync
		&& !long_sel) |=> !counting [*8] ##[240:250] counting)
		else $error("short wake delay wrong");
	sw_reset_a: assert property (sw_fire |=> chip_reset_req)
		else $error("software reset not produced");

	// main scenarios the bench should reach
	cover_expiry_c: cover property (expire_fire);
	cover_long_wake_c: cover property (state == wwdg_pkg::WWDG_WAKE
		&& long_sel);
	cover_halt_wake_c: cover property (state == wwdg_pkg::WWDG_WAKE
		##1 counting);
	cover_act_halt_c: cover property (go_act ##[1:50] counting);
	cover_sw_reset_c: cover property (sw_fire);
endmodule : wwdg_top
`default_nettype wire

//--- tb/wwdg_reset_model.sv
// partner model: chip reset logic behind the open-drain reset pin
// assumes one clock shared with the watchdog and a pull-up on the pin
`timescale 1ns/1ps
`default_nettype none
module wwdg_reset_model (
	input wire logic clk,
	input wire logic por_n,
	input wire logic rst_pin_o,
	input wire logic rst_pin_oe,
	output logic arst_n,
	output int resets,
	output int low_width
);
	logic pin;
	logic hold;
	int run;
	// pull-up wins while nobody drives
	assign pin = rst_pin_oe ? rst_pin_o : 1'b1;
	assign arst_n = por_n & ~hold;
	initial
	begin
		resets = 0;
		low_width = 0;
		run = 0;
		hold = 1'b0;
	end
	// measure the low time, then reset the chip once the pin is let go
	always @(posedge clk)
	begin
		hold <= 1'b0;
		if (!por_n)
			run <= 0;
		else if (pin === 1'b0)
			run <= run + 1;
		else if (run > 0)
		begin
			low_width <= run;
			resets <= resets + 1;
			run <= 0;
			hold <= 1'b1;
		end
	end
endmodule : wwdg_reset_model
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the halt-aware watchdog
// assumes the reset model feeds arst_n; prescaler shortened to 16
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int P = 16;
	localparam logic [7:0] CR = wwdg_pkg::CTRL_OFF;
	localparam logic [7:0] ST = wwdg_pkg::STATUS_OFF;
	localparam logic [7:0] MK = wwdg_pkg::MASK_OFF;
	logic clk, por_n, arst_n, reg_wr, reg_rd, hw_opt, halt_opt, ah_rst;
	logic rtc, halt_req, ext_irq, osc_irq, chip_reset_req, wd_long;
	logic rst_pin_o, rst_pin_oe, cpu_halted, irq;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	int resets, low_width, cyc, err_count, checks;
	wwdg_top #(.PRESCALE_CYC(P)) u_dut (.clk(clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_wdg_option(hw_opt),
		.halt_reset_option(halt_opt), .wake_delay_long(wd_long),
		.active_halt_reset(ah_rst), .rtc_irq_enable(rtc),
		.halt_req(halt_req), .ext_irq_pin(ext_irq), .osc_irq(osc_irq),
		.chip_reset_req(chip_reset_req), .rst_pin_o(rst_pin_o),
		.rst_pin_oe(rst_pin_oe), .cpu_halted(cpu_halted), .irq(irq));
	wwdg_reset_model u_rst (.clk(clk), .por_n(por_n),
		.rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .arst_n(arst_n),
		.resets(resets), .low_width(low_width));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
		cyc <= cyc + 1;
	task automatic complete_run();
		if (err_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask : rd
	task automatic hlt();
		halt_req <= 1'b1;
		@(posedge clk);
		halt_req <= 1'b0;
	endtask : hlt
	task automatic por(input logic hw, input logic ho, input logic ah);
		por_n <= 1'b0;
		hw_opt <= hw;
		halt_opt <= ho;
		ah_rst <= ah;
		repeat (3) @(posedge clk);
		por_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : por
	task automatic wait_rst(input int r0, input int lim);
		int n;
		n = 0;
		while (resets == r0 && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		chk({7'h00, resets != r0}, 8'h01);
		repeat (3) @(posedge clk);
	endtask : wait_rst
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 3 * P)
		begin
			@(posedge clk);
			n++;
		end
	endtask : wait_irq
	task automatic t_regs();
		logic [7:0] d;
		rd(CR, d);
		chk(d, 8'h7F);
		rd(8'h2B, d);
		chk(d, 8'h00);
		rd(ST, d);
		chk(d, 8'h00);
	endtask : t_regs
	task automatic t_idle();
		logic [7:0] d;
		int c1, r0;
		r0 = resets;
		wr(MK, 8'h01);
		wr(CR, 8'h41);
		wait_irq();
		c1 = cyc;
		wr(ST, 8'h01);
		wr(CR, 8'h40);
		repeat (3) @(posedge clk);
		wait_irq();
		chk(8'(cyc - c1), 8'(P));
		chk(8'(resets - r0), 8'h00);
		rd(CR, d);
		chk(d, 8'h3F);
		wr(ST, 8'h01);
		wr(MK, 8'h06);
	endtask : t_idle
	task automatic t_sticky();
		logic [7:0] d;
		wr(CR, 8'hFF);
		wr(CR, 8'h7F);
		rd(CR, d);
		chk({7'h00, d[7]}, 8'h01);
	endtask : t_sticky
	task automatic t_halt();
		logic [7:0] d;
		int r0, n;
		r0 = resets;
		wr(CR, 8'hFF);
		hlt();
		repeat (5 * P) @(posedge clk);
		chk({7'h00, cpu_halted}, 8'h01);
		rd(CR, d);
		chk(d, 8'hFE);
		chk(8'(resets - r0), 8'h00);
		ext_irq <= 1'b1;
		n = 0;
		while (cpu_halted !== 1'b0 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		ext_irq <= 1'b0;
		rd(CR, d);
		chk(d, 8'hFE);
		repeat (200) @(posedge clk);
		rd(CR, d);
		chk(d, 8'hFE);
		repeat (80) @(posedge clk);
		rd(CR, d);
		chk({7'h00, d < 8'hFE}, 8'h01);
		rd(ST, d);
		chk(d, 8'h06);
		chk({7'h00, irq}, 8'h01);
		wr(ST, 8'h06);
		repeat (2) @(posedge clk);
		chk({7'h00, irq}, 8'h00);
	endtask : t_halt
	task automatic t_act_halt();
		logic [7:0] d;
		rtc <= 1'b1;
		wr(CR, 8'hFF);
		hlt();
		repeat (5 * P) @(posedge clk);
		chk({7'h00, cpu_halted}, 8'h01);
		rd(CR, d);
		chk(d, 8'hFF);
		osc_irq <= 1'b1;
		@(posedge clk);
		osc_irq <= 1'b0;
		repeat (3) @(posedge clk);
		chk({7'h00, cpu_halted}, 8'h00);
		repeat (P + 2) @(posedge clk);
		rd(CR, d);
		chk({7'h00, d < 8'hFF}, 8'h01);
		rtc <= 1'b0;
	endtask : t_act_halt
	task automatic t_sw_reset();
		logic [7:0] d;
		int r0;
		r0 = resets;
		wr(CR, 8'hBF);
		wait_rst(r0, 60);
		chk(8'(low_width), 8'(wwdg_pkg::RST_PULSE_CYC));
		rd(CR, d);
		chk(d, 8'h7F);
	endtask : t_sw_reset
	task automatic t_expiry();
		logic [7:0] d;
		int r0;
		r0 = resets;
		wr(CR, 8'hC1);
		repeat (P - 1) @(posedge clk);
		chk({7'h00, chip_reset_req}, 8'h00);
		wait_rst(r0, 2 * P + 40);
		rd(CR, d);
		chk(d, 8'h7F);
	endtask : t_expiry
	task automatic t_halt_reset();
		int r0;
		por(1'b0, 1'b1, 1'b0);
		r0 = resets;
		wr(CR, 8'hFF);
		hlt();
		repeat (3) @(posedge clk);
		chk({7'h00, cpu_halted}, 8'h00);
		wait_rst(r0, 60);
	endtask : t_halt_reset
	task automatic t_hw_wake();
		logic [7:0] d;
		int r0;
		por(1'b1, 1'b0, 1'b1);
		r0 = resets;
		repeat (200) @(posedge clk);
		rd(CR, d);
		chk({1'b0, d[6:0]}, 8'h7F);
		repeat (100) @(posedge clk);
		rd(CR, d);
		chk({7'h00, d[6:0] < 7'h7F}, 8'h01);
		wait_rst(r0, 64 * P + 100);
	endtask : t_hw_wake
	task automatic t_long_wake();
		logic [7:0] d;
		wd_long <= 1'b1;
		por(1'b0, 1'b0, 1'b1);
		repeat (4000) @(posedge clk);
		rd(CR, d);
		chk(d, 8'h7F);
		repeat (120) @(posedge clk);
		rd(CR, d);
		chk({7'h00, d < 8'h7F}, 8'h01);
	endtask : t_long_wake
	initial
	begin
		{por_n, reg_wr, reg_rd, hw_opt, halt_opt, ah_rst} = '0;
		{rtc, halt_req, ext_irq, osc_irq, wd_long} = '0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		cyc = 0;
		err_count = 0;
		checks = 0;
		por(1'b0, 1'b0, 1'b0);
		t_regs();
		t_idle();
		t_sticky();
		t_halt();
		t_act_halt();
		t_sw_reset();
		t_expiry();
		t_halt_reset();
		t_hw_wake();
		t_long_wake();
		complete_run();
	end
	initial
	begin
		#200000;
		err_count++;
		complete_run();
	end
endmodule : testbench
`default_nettype wire
